//--- core/psrsc_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - hardware standby floats every pin; software standby keeps port outputs
// - reset during an external access returns every port to input at once
// - reset drives address, read and write strobes high and floats data
// - reset in state one or three-state area state two: address bus low half a state later in modes 1 and 3
// - the reset pin is sampled on the falling clock edge
// - reset in a wait state behaves like reset in state two
// - reset in state three or two-state area state two holds address
// - reset output floats in reset, drives low only on watchdog reset
// - mode 3 upper pins: address when control bit 0, else keep port
// - expanded modes: port 8 bit 1 input or driven high by direction
// - expanded modes: strobes high during reset, floating in both standbys
module psrsc_top
  import psrsc_pkg::*;
#(
  parameter int AW = 12,
  parameter int WDR_LEN = WDR_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RESET_N_IN,
  input wire logic HW_STANDBY_N,
  input wire logic SW_STANDBY,
  input wire logic [2:0] MODE,
  input wire psrsc_bus_t BUS,
  input wire logic WATCHDOG_TIMER_OVF,
  output logic [ADDR_W-1:0] ADDR_O,
  output logic [ADDR_W-1:0] ADDR_OE_N,
  output psrsc_strb_t STRB_O,
  output logic STRB_OE_N,
  output logic [DATA_W-1:0] DATA_O,
  output logic DATA_OE_N,
  output logic [PIO_W-1:0] PIO_O,
  output logic [PIO_W-1:0] PIO_OE_N,
  output logic P81_O,
  output logic P81_OE_N,
  output logic RESET_OUT_N,
  output logic RESET_OUT_N_OE_N
);

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [11:0] ofs);
    hit = (a == AW'(ofs));
  endfunction

  logic in_res;
  logic [LOW_CNT_W-1:0] low_cnt;

  psrsc_rsamp #(.CW(LOW_CNT_W)) u_rsamp (
    .CLK(CLK),
    .RST(RST),
    .RESET_N_IN(RESET_N_IN),
    .res_act(in_res),
    .low_cnt(low_cnt)
  );

  logic hw, sw, run, expd, wide, newres, holdc;

  // ---------------- register group ----------------
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [1:0] sys_q, sys_d;
  logic [PIO_W-1:0] dr_q, dr_d, ddr_q, ddr_d;
  logic p81_dr_q, p81_dr_d, p81_ddr_q, p81_ddr_d;
  logic [UP_W-1:0] up_dr_q, up_dr_d, up_ddr_q, up_ddr_d;
  logic ram_lost_q, ram_lost_d, rec_err_q, rec_err_d;
  logic hw_prev_q, res_prev_q;
  logic [WDR_CNT_W-1:0] wdr_q, wdr_d;
  logic acc, wr_en, ram_en, adr_ctl;
  logic [31:0] port_rd, stat_rd;

  assign hw = !HW_STANDBY_N;
  assign sw = SW_STANDBY;
  assign run = !in_res && !hw && !sw;
  assign expd = (MODE == MODE_1) || (MODE == MODE_3) || (MODE == MODE_5);
  assign wide = (MODE == MODE_3);
  assign newres = in_res && !res_prev_q;
  assign holdc = (BUS.state == BUS_STATE_THREE) ||
                 (BUS.state == BUS_STATE_TWO && BUS.two_state);
  assign ram_en = sys_q[SYS_RAM_EN_BIT];
  assign adr_ctl = sys_q[SYS_ADDR_CTRL_BIT];
  assign acc = PSEL && PENABLE && !pready_q;
  // a write lands on the edge where the master sees pready high
  assign wr_en = PSEL && PENABLE && PWRITE && pready_q;

  always_comb begin
    port_rd = '0;
    port_rd[PC_DR_LSB +: PIO_W] = dr_q;
    port_rd[PC_DDR_LSB +: PIO_W] = ddr_q;
    port_rd[PC_P81_DR_BIT] = p81_dr_q;
    port_rd[PC_P81_DDR_BIT] = p81_ddr_q;
    port_rd[PC_UP_DR_LSB +: UP_W] = up_dr_q;
    port_rd[PC_UP_DDR_LSB +: UP_W] = up_ddr_q;
    stat_rd = '0;
    stat_rd[ST_IN_RESET_BIT] = in_res;
    stat_rd[ST_HW_HW_STANDBY_N_BIT] = hw;
    stat_rd[ST_SW_HW_STANDBY_N_BIT] = sw;
    stat_rd[ST_RAM_LOST_BIT] = ram_lost_q;
    stat_rd[ST_REC_ERR_BIT] = rec_err_q;
    stat_rd[ST_WDR_BIT] = (wdr_q != '0);
  end

  always_comb begin
    pready_d = acc;
    pslverr_d = 1'b0;
    {prdata_d, sys_d, dr_d, ddr_d, p81_dr_d, p81_ddr_d} =
      {prdata_q, sys_q, dr_q, ddr_q, p81_dr_q, p81_ddr_q};
    {up_dr_d, up_ddr_d, ram_lost_d, rec_err_d, wdr_d} =
      {up_dr_q, up_ddr_q, ram_lost_q, rec_err_q, wdr_q};
    if (acc) begin
      prdata_d = '0;
      if (hit(PADDR, OFS_SYS_CTRL)) begin
        prdata_d[1:0] = sys_q;
      end else if (hit(PADDR, OFS_PORT_CTRL)) begin
        prdata_d = port_rd;
      end else if (hit(PADDR, OFS_STATUS)) begin
        prdata_d = stat_rd;
      end else begin
        pslverr_d = 1'b1;
      end
    end
    if (wr_en) begin
      if (hit(PADDR, OFS_SYS_CTRL)) begin
        sys_d = PWDATA[1:0];
      end else if (hit(PADDR, OFS_PORT_CTRL)) begin
        dr_d = PWDATA[PC_DR_LSB +: PIO_W];
        ddr_d = PWDATA[PC_DDR_LSB +: PIO_W];
        p81_dr_d = PWDATA[PC_P81_DR_BIT];
        p81_ddr_d = PWDATA[PC_P81_DDR_BIT];
        up_dr_d = PWDATA[PC_UP_DR_LSB +: UP_W];
        up_ddr_d = PWDATA[PC_UP_DDR_LSB +: UP_W];
      end else if (hit(PADDR, OFS_STATUS)) begin
        if (PWDATA[ST_RAM_LOST_BIT]) begin
          ram_lost_d = 1'b0;
        end
        if (PWDATA[ST_REC_ERR_BIT]) begin
          rec_err_d = 1'b0;
        end
      end
    end
    // directions fall back to input while the pin reset is held
    if (in_res) begin
      ddr_d = '0;
      p81_ddr_d = 1'b0;
      up_ddr_d = '0;
    end
    // sequencing checks on the controller; set wins over a clear
    if (hw && !hw_prev_q && ram_en &&
        (!in_res || low_cnt <= LOW_CNT_W'(RES_LEAD_CYC))) begin
      ram_lost_d = 1'b1;
    end
    if (!hw && hw_prev_q &&
        (!in_res || low_cnt <= LOW_CNT_W'(REC_LEAD_CYC))) begin
      rec_err_d = 1'b1;
    end
    // watchdog reset stretch; a pin reset cancels it
    if (in_res || hw) begin
      wdr_d = '0;
    end else if (WATCHDOG_TIMER_OVF) begin
      wdr_d = WDR_CNT_W'(WDR_LEN);
    end else if (wdr_q != '0) begin
      wdr_d = wdr_q - WDR_CNT_W'(1);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      {pready_q, prdata_q, pslverr_q, dr_q, ddr_q, p81_dr_q} <= '0;
      {p81_ddr_q, up_dr_q, up_ddr_q, ram_lost_q, rec_err_q} <= '0;
      {hw_prev_q, res_prev_q, wdr_q} <= '0;
      sys_q <= SYS_RESET_VAL;
    end else begin
      {pready_q, prdata_q, pslverr_q, sys_q, dr_q, ddr_q} <=
        {pready_d, prdata_d, pslverr_d, sys_d, dr_d, ddr_d};
      {p81_dr_q, p81_ddr_q, up_dr_q, up_ddr_q} <=
        {p81_dr_d, p81_ddr_d, up_dr_d, up_ddr_d};
      {ram_lost_q, rec_err_q, hw_prev_q, res_prev_q, wdr_q} <=
        {ram_lost_d, rec_err_d, hw, in_res, wdr_d};
    end
  end

  assign {PREADY, PRDATA, PSLVERR} = {pready_q, prdata_q, pslverr_q};

  // ---------------- pin group ----------------
  logic [ADDR_W-1:0] addr_q, addr_d, aoe_q, aoe_d;
  psrsc_strb_t strb_q, strb_d;
  logic soe_q, soe_d, doe_q, doe_d, p81_q, p81_d, p81oe_q, p81oe_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic [PIO_W-1:0] pio_q, pio_d, pioe_q, pioe_d;
  logic ro_q, ro_d, rooe_q, rooe_d;
  logic active;

  assign active = (BUS.state != BUS_IDLE);

  always_comb begin
    {addr_d, aoe_d, strb_d, soe_d, data_d, pio_d} =
      {addr_q, aoe_q, strb_q, soe_q, data_q, pio_q};
    {pioe_d, p81_d, p81oe_d} = {pioe_q, p81_q, p81oe_q};
    doe_d = 1'b1;
    ro_d = 1'b0;
    rooe_d = (wdr_d == '0);
    if (hw) begin
      aoe_d = '1;
      soe_d = 1'b1;
      pioe_d = '1;
      p81oe_d = 1'b1;
      rooe_d = 1'b1;
    end else if (in_res) begin
      pioe_d = '1;
      p81oe_d = 1'b1;
      strb_d = '1;
      soe_d = !expd;
      if (!(newres && holdc)) begin
        addr_d = '0;
        aoe_d = '1;
        if (MODE == MODE_1 || wide) begin
          aoe_d[ADDR_LOW_TOP:0] = '0;
        end
        aoe_d[ADDR_A20] = !wide;
      end // address kept for the rest of the state
    end else if (sw) begin
      // keep: port outputs hold level and enable; address and strobes float
      aoe_d[ADDR_UP_LSB-1:0] = '1;
      if (!(wide && adr_ctl)) begin
        aoe_d[ADDR_W-1:ADDR_UP_LSB] = '1;
      end
      soe_d = 1'b1;
      if (expd) begin
        p81_d = 1'b1;
        p81oe_d = !p81_ddr_q;
      end
    end else begin
      if (expd) begin
        addr_d = BUS.addr;
        aoe_d = '1;
        aoe_d[ADDR_LOW_TOP:0] = '0;
        if (wide) begin
          aoe_d[ADDR_A20] = 1'b0;
          if (adr_ctl) begin
            addr_d[ADDR_UP_LSB +: UP_W] = up_dr_q;
            aoe_d[ADDR_UP_LSB +: UP_W] = ~up_ddr_q;
          end else begin
            aoe_d[ADDR_UP_LSB +: UP_W] = '0;
          end
        end
        strb_d.addr_strobe_n = !active;
        strb_d.rd_strobe_n = !(active && BUS.rd);
        strb_d.wr_strobe_n = !(active && BUS.wr &&
                               BUS.state != BUS_STATE_ONE);
        soe_d = 1'b0;
        data_d = BUS.wdata;
        doe_d = !(active && BUS.wr && BUS.state != BUS_STATE_ONE);
        p81_d = 1'b1;
        p81oe_d = !p81_ddr_q;
      end else begin
        aoe_d = '1;
        soe_d = 1'b1;
        p81_d = p81_dr_q;
        p81oe_d = !p81_ddr_q;
      end
      pio_d = dr_q;
      pioe_d = ~ddr_q;
    end
    if (in_res || hw) begin
      doe_d = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      {addr_q, data_q, pio_q, p81_q, ro_q} <= '0;
      {aoe_q, strb_q, soe_q, doe_q, pioe_q, p81oe_q, rooe_q} <= '1;
    end else begin
      {addr_q, aoe_q, strb_q, soe_q, data_q, doe_q} <=
        {addr_d, aoe_d, strb_d, soe_d, data_d, doe_d};
      {pio_q, pioe_q, p81_q, p81oe_q, ro_q, rooe_q} <=
        {pio_d, pioe_d, p81_d, p81oe_d, ro_d, rooe_d};
    end
  end

  assign {ADDR_O, ADDR_OE_N, STRB_O, STRB_OE_N, DATA_O, DATA_OE_N} =
    {addr_q, aoe_q, strb_q, soe_q, data_q, doe_q};
  assign {PIO_O, PIO_OE_N, P81_O, P81_OE_N, RESET_OUT_N} =
    {pio_q, pioe_q, p81_q, p81oe_q, ro_q};
  assign RESET_OUT_N_OE_N = rooe_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_hw_hw_standby_n_float: assert property (hw |=>
    (&ADDR_OE_N) && STRB_OE_N && DATA_OE_N && (&PIO_OE_N) && P81_OE_N)
    else $error("pins driven in hardware standby");
  a_sw_keep_out: assert property (sw && !hw && !in_res ##1
    sw && !hw && !in_res |=> $stable(PIO_O) && $stable(PIO_OE_N))
    else $error("port output changed in software standby");
  a_reset_port_in: assert property (in_res |=> (&PIO_OE_N) && P81_OE_N)
    else $error("port not input during reset");
  a_reset_strobe_hi: assert property (in_res && !hw |=>
    STRB_O == '1 && DATA_OE_N && STRB_OE_N == !$past(expd))
    else $error("strobes or data wrong during reset");
  a_addr_low_half: assert property (newres && !holdc && !hw &&
    (MODE == MODE_1 || wide) |=>
    ADDR_O == '0 && ADDR_OE_N[ADDR_LOW_TOP:0] == '0)
    else $error("address not low half a state after reset sample");
  a_addr_hold_three: assert property (newres && holdc && !hw
    ##1 in_res && !hw |-> $stable(ADDR_O) ##1 ADDR_O == '0)
    else $error("address not held for the rest of the state");
  a_reset_out_n_float: assert property (in_res |=> RESET_OUT_N_OE_N)
    else $error("reset output driven during pin reset");
  a_reset_out_n_wd_low: assert property (WATCHDOG_TIMER_OVF && !in_res && !hw
    |=> !RESET_OUT_N_OE_N [*4])
    else $error("watchdog reset not driven low");
  a_upper_addr: assert property (run && wide && !adr_ctl |=>
    ADDR_OE_N[ADDR_W-1:ADDR_UP_LSB] == '0)
    else $error("upper address pins not driven");
  a_p81_high: assert property ((run || (sw && !in_res && !hw)) &&
    expd && p81_ddr_q |=> P81_O && !P81_OE_N)
    else $error("port 8 bit 1 not driven high");
  a_ddr_cleared: assert property ($fell(in_res) && !hw &&
    !wr_en |=> ddr_q == '0)
    else $error("direction not cleared by reset");

endmodule

//--- core/psrsc_pkg.sv
package psrsc_pkg;

  // timing
  localparam int CLK_NS = 50;
  localparam int REC_LEAD_NS = 100;
  localparam int REC_LEAD_CYC_RAW = (REC_LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_LEAD_CYC = (REC_LEAD_CYC_RAW < 1) ? 1 : REC_LEAD_CYC_RAW;
  localparam int RES_LEAD_CYC = 10;
  localparam int LOW_CNT_W = 4;
  localparam int WDR_CYC = 16;
  localparam int WDR_CNT_W = 5;

  // register map (byte addresses)
  localparam logic [11:0] OFS_SYS_CTRL = 12'h000;
  localparam logic [11:0] OFS_PORT_CTRL = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;

  // system_control_reg fields
  localparam int SYS_RAM_EN_BIT = 0;
  localparam int SYS_ADDR_CTRL_BIT = 1;
  localparam logic [1:0] SYS_RESET_VAL = 2'h1;

  // port control fields
  localparam int PC_DR_LSB = 0;
  localparam int PC_DDR_LSB = 8;
  localparam int PC_P81_DR_BIT = 16;
  localparam int PC_P81_DDR_BIT = 17;
  localparam int PC_UP_DR_LSB = 18;
  localparam int PC_UP_DDR_LSB = 21;

  // status fields
  localparam int ST_IN_RESET_BIT = 0;
  localparam int ST_HW_HW_STANDBY_N_BIT = 1;
  localparam int ST_SW_HW_STANDBY_N_BIT = 2;
  localparam int ST_RAM_LOST_BIT = 3;
  localparam int ST_REC_ERR_BIT = 4;
  localparam int ST_WDR_BIT = 5;

  // pin geometry
  localparam int ADDR_W = 24;
  localparam int ADDR_LOW_TOP = 19;
  localparam int ADDR_A20 = 20;
  localparam int ADDR_UP_LSB = 21;
  localparam int UP_W = 3;
  localparam int PIO_W = 8;
  localparam int DATA_W = 8;

  // operating modes
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_5 = 3'h5;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_STATE_ONE,
    BUS_STATE_TWO,
    BUS_STATE_THREE,
    BUS_WAIT_STATE
  } psrsc_bstate_t;

  typedef struct packed {
    psrsc_bstate_t state;
    logic two_state;
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [7:0] wdata;
  } psrsc_bus_t;

  typedef struct packed {
    logic addr_strobe_n;
    logic rd_strobe_n;
    logic wr_strobe_n;
  } psrsc_strb_t;

endpackage

//--- core/psrsc_rsamp.sv
`timescale 1ns/10ps
// reset pin sampler: runs on the falling clock edge so that the pin
// logic on the rising edge acts half a state after the sample
module psrsc_rsamp
  import psrsc_pkg::*;
#(
  parameter int CW = LOW_CNT_W
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RESET_N_IN,
  output logic res_act,
  output logic [CW-1:0] low_cnt
);

  logic res_act_q, res_act_d;
  logic [CW-1:0] cnt_q, cnt_d;

  always_comb begin
    res_act_d = !RESET_N_IN;
    cnt_d = cnt_q;
    if (RESET_N_IN) begin
      cnt_d = '0;
    end else if (cnt_q != {CW{1'b1}}) begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(negedge CLK) begin
    if (RST) begin
      res_act_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      res_act_q <= res_act_d;
      cnt_q <= cnt_d;
    end
  end

  assign res_act = res_act_q;
  assign low_cnt = cnt_q;

  a_sample_fall: assert property (@(negedge CLK) disable iff (RST)
    !RESET_N_IN |=> res_act_q)
    else $error("reset pin low not caught at falling edge");

endmodule

//--- tb/psrsc_ctrl_model.sv
`timescale 1ns/10ps
// board reset/standby controller; the bench calls its tasks
module psrsc_ctrl_model
  import psrsc_pkg::*;
(
  input wire logic CLK,
  output logic RESET_N_IN,
  output logic HW_STANDBY_N
);
  initial begin
    RESET_N_IN = 1'b1;
    HW_STANDBY_N = 1'b1;
  end

  task automatic set_res(input logic v);
    @(posedge CLK);
    RESET_N_IN <= v;
  endtask

  // lead 0 skips the reset lead; with RAM enabled that is a deliberate
  // breach that only the bench asks for
  task automatic enter_hw_standby_n(input int lead);
    @(posedge CLK);
    if (lead > 0) begin
      RESET_N_IN <= 1'b0;
      repeat (lead) @(posedge CLK);
    end
    HW_STANDBY_N <= 1'b0;
    @(posedge CLK);
    RESET_N_IN <= 1'b1;
  endtask

  task automatic leave_hw_standby_n(input int lead);
    @(posedge CLK);
    RESET_N_IN <= 1'b0;
    repeat (lead) @(posedge CLK);
    HW_STANDBY_N <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET_N_IN <= 1'b1;
  endtask
endmodule

//--- tb/psrsc_bench.sv
`timescale 1ns/10ps
module psrsc_bench;
  import psrsc_pkg::*;
  localparam int WDL = 4;
  localparam logic [23:0] TADDR = 24'h0ABCDE;
  localparam logic [31:0] PCFG = 32'h00F7FFA5;
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic RESET_N_IN, HW_STANDBY_N, SW_STANDBY, WATCHDOG_TIMER_OVF, err;
  logic [2:0] MODE;
  psrsc_bus_t BUS;
  logic [ADDR_W-1:0] ADDR_O, ADDR_OE_N;
  psrsc_strb_t STRB_O;
  logic STRB_OE_N, DATA_OE_N, P81_O, P81_OE_N;
  logic RESET_OUT_N, RESET_OUT_N_OE_N;
  logic [DATA_W-1:0] DATA_O;
  logic [PIO_W-1:0] PIO_O, PIO_OE_N;
  int n_errors, num_checks, cycles;

  psrsc_top #(.WDR_LEN(WDL)) i_psrsc_top (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RESET_N_IN(RESET_N_IN),
    .HW_STANDBY_N(HW_STANDBY_N), .SW_STANDBY(SW_STANDBY), .MODE(MODE),
    .BUS(BUS), .WATCHDOG_TIMER_OVF(WATCHDOG_TIMER_OVF), .ADDR_O(ADDR_O),
    .ADDR_OE_N(ADDR_OE_N), .STRB_O(STRB_O), .STRB_OE_N(STRB_OE_N),
    .DATA_O(DATA_O), .DATA_OE_N(DATA_OE_N), .PIO_O(PIO_O),
    .PIO_OE_N(PIO_OE_N), .P81_O(P81_O), .P81_OE_N(P81_OE_N),
    .RESET_OUT_N(RESET_OUT_N), .RESET_OUT_N_OE_N(RESET_OUT_N_OE_N)
  );

  psrsc_ctrl_model i_psrsc_ctrl_model (
    .CLK(CLK), .RESET_N_IN(RESET_N_IN), .HW_STANDBY_N(HW_STANDBY_N)
  );

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // the request is held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic t_reset_vals();
    #1;
    chk(ADDR_OE_N, 24'hFFFFFF);
    chk(PIO_OE_N, 8'hFF);
    chk(STRB_O, 3'h7);
    apb(1'b0, OFS_SYS_CTRL, 32'h0);
    chk(rd, 32'h00000001);
    apb(1'b0, 12'h00C, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask

  task automatic t_bus_reset(input psrsc_bstate_t s, input logic two);
    logic hold;
    hold = (s == BUS_STATE_THREE) || (s == BUS_STATE_TWO && two);
    apb(1'b1, OFS_PORT_CTRL, 32'h0000FF5A);
    @(posedge CLK);
    BUS <= '{s, two, 1'b1, 1'b0, TADDR, 8'h3C};
    repeat (2) @(posedge CLK);
    #1;
    chk(PIO_OE_N, 8'h00);
    chk(PIO_O, 8'h5A);
    chk(ADDR_O, TADDR);
    chk(STRB_O, 3'h1);
    chk(DATA_O, 8'h3C);
    i_psrsc_ctrl_model.set_res(1'b0);
    @(posedge CLK);
    #1;
    chk(PIO_OE_N, 8'hFF);
    chk(STRB_O, 3'h7);
    chk(STRB_OE_N, 1'b0);
    chk(DATA_OE_N, 1'b1);
    chk(RESET_OUT_N_OE_N, 1'b1);
    if (hold) begin
      chk(ADDR_O, TADDR);
      @(posedge CLK);
      #1;
    end
    chk(ADDR_O, 24'h0);
    chk(ADDR_OE_N, (MODE == MODE_1) ? 24'hF00000 : 24'hE00000);
    @(posedge CLK);
    BUS <= '0;
    i_psrsc_ctrl_model.set_res(1'b1);
    repeat (3) @(posedge CLK);
    #1;
    chk(PIO_OE_N, 8'hFF);
    apb(1'b0, OFS_PORT_CTRL, 32'h0);
    chk(rd[15:8], 8'h00);
  endtask

  task automatic t_hw_hw_standby_n(input int lead, input logic ram, input int rlead,
                           input logic lost, input logic rec);
    apb(1'b1, OFS_SYS_CTRL, {31'h0, ram});
    apb(1'b1, OFS_PORT_CTRL, PCFG);
    i_psrsc_ctrl_model.enter_hw_standby_n(lead);
    repeat (2) @(posedge CLK);
    #1;
    chk(PIO_OE_N, 8'hFF);
    chk(ADDR_OE_N, 24'hFFFFFF);
    chk(DATA_OE_N, 1'b1);
    chk(P81_OE_N, 1'b1);
    chk(STRB_OE_N, 1'b1);
    i_psrsc_ctrl_model.leave_hw_standby_n(rlead);
    repeat (3) @(posedge CLK);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[3], lost);
    chk(rd[4], rec);
    apb(1'b1, OFS_STATUS, 32'h00000018);
  endtask

  task automatic t_sw_hw_standby_n(input logic actrl);
    apb(1'b1, OFS_SYS_CTRL, {30'h0, actrl, 1'b1});
    apb(1'b1, OFS_PORT_CTRL, PCFG);
    @(posedge CLK);
    SW_STANDBY <= 1'b1;
    repeat (2) @(posedge CLK);
    #1;
    chk(PIO_OE_N, 8'h00);
    chk(PIO_O, 8'hA5);
    chk(STRB_OE_N, 1'b1);
    chk(P81_O, 1'b1);
    chk(P81_OE_N, 1'b0);
    chk(ADDR_OE_N[20:0], 21'h1FFFFF);
    chk(ADDR_OE_N[23:21], actrl ? 3'h0 : 3'h7);
    if (actrl) begin
      chk(ADDR_O[23:21], 3'h5);
    end
    @(posedge CLK);
    SW_STANDBY <= 1'b0;
  endtask

  task automatic t_wdt();
    int cnt;
    cnt = 0;
    @(posedge CLK);
    WATCHDOG_TIMER_OVF <= 1'b1;
    @(posedge CLK);
    WATCHDOG_TIMER_OVF <= 1'b0;
    repeat (WDL + 4) begin
      #1;
      if (RESET_OUT_N_OE_N === 1'b0 && RESET_OUT_N === 1'b0) begin
        cnt++;
      end
      @(posedge CLK);
    end
    chk(cnt, WDL);
  endtask

  initial begin
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    SW_STANDBY = 1'b0;
    MODE = MODE_3;
    BUS = '0;
    WATCHDOG_TIMER_OVF = 1'b0;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    t_reset_vals();
    t_bus_reset(BUS_STATE_ONE, 1'b0);
    t_bus_reset(BUS_STATE_TWO, 1'b0);
    t_bus_reset(BUS_WAIT_STATE, 1'b0);
    t_bus_reset(BUS_STATE_THREE, 1'b0);
    t_bus_reset(BUS_STATE_TWO, 1'b1);
    @(posedge CLK);
    MODE <= MODE_1;
    t_bus_reset(BUS_STATE_ONE, 1'b0);
    t_bus_reset(BUS_STATE_THREE, 1'b0);
    @(posedge CLK);
    MODE <= MODE_3;
    t_hw_hw_standby_n(12, 1'b1, 4, 1'b0, 1'b0);
    t_hw_hw_standby_n(0, 1'b0, 4, 1'b0, 1'b0);
    t_hw_hw_standby_n(0, 1'b1, 1, 1'b1, 1'b1);
    t_sw_hw_standby_n(1'b0);
    t_sw_hw_standby_n(1'b1);
    t_wdt();
    close_out();
  end
endmodule
